// file: hdl/ria_top.sv
// Interrupt flag, mask and polarity logic with its host register port.
// Assumes event inputs are one-cycle pulses synchronous to clk_in.
`timescale 1ns/1ns
module ria_top (
  input  wire logic             clk_in,
  input  wire logic             rst_in,
  input  wire ria_pkg::ria_req_t req_in,
  input  wire ria_pkg::ria_evt_t evt_in,
  input  wire logic [7:0]       rssi_sample_in,
  input  wire logic             rssi_valid_in,
  input  wire logic [7:0]       tx_outcome_in,
  output logic [7:0]            rdata_out,
  output logic                  irq_out,
  output logic                  sleep_clock_off_out
);
  logic [7:0] irq_event_flags_ff;
  logic [7:0] irq_source_mask_ff;
  logic [1:0] cfg_ff;
  logic [7:0] rssi_ff;
  logic [7:0] tx_outcome_reg_ff;
  logic [7:0] rdata_ff;
  logic       irq_ff;
  logic [7:0] evt_vec;
  logic [7:0] enabled_flags;
  logic       flags_rd;
  logic       mask_wr;
  logic       cfg_wr;
  logic       pending;

  // Address decode shared by the register writes, the flag read clear and the checks.
  function automatic logic reg_write_hit(
    input ria_pkg::ria_req_t req,
    input logic [7:0]        addr
  );
    return req.wr && (req.addr == addr);
  endfunction

  function automatic logic reg_read_hit(
    input ria_pkg::ria_req_t req,
    input logic [7:0]        addr
  );
    return req.rd && (req.addr == addr);
  endfunction

  // Pin level for a pending state under the programmed polarity.
  function automatic logic pin_level(
    input logic pend,
    input logic pol
  );
    return pol ? pend : ~pend;
  endfunction

  // Bit order of the struct matches the flag layout, so a cast places each event.
  assign evt_vec  = evt_in; // RULE8
  assign flags_rd = reg_read_hit(req_in, ria_pkg::ADDR_FLAGS);
  assign mask_wr  = reg_write_hit(req_in, ria_pkg::ADDR_MASK);
  assign cfg_wr   = reg_write_hit(req_in, ria_pkg::ADDR_CFG);

  // Set wins over the read clear so a coincident event is reported next time.
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      irq_event_flags_ff <= ria_pkg::FLAGS_RST; // RULE2
    end
    else if (flags_rd)
    begin
      irq_event_flags_ff <= evt_vec; // RULE2 RULE15 RULE13 RULE14
    end
    else
    begin
      irq_event_flags_ff <= irq_event_flags_ff | evt_vec;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      irq_source_mask_ff <= ria_pkg::MASK_RST; // RULE3
    end
    else if (mask_wr)
    begin
      irq_source_mask_ff <= req_in.wdata; // RULE9
    end
  end

  // Only the two implemented bits are stored, so the upper ones cannot read back.
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      cfg_ff <= ria_pkg::CFG_RST; // RULE4 RULE10
    end
    else if (cfg_wr)
    begin
      cfg_ff <= req_in.wdata[1:0]; // RULE11
    end
  end

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      rssi_ff <= ria_pkg::DATA_RST;
    end
    else if (rssi_valid_in)
    begin
      rssi_ff <= rssi_sample_in; // RULE12
    end
  end

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      tx_outcome_reg_ff <= ria_pkg::DATA_RST;
    end
    else if (evt_in.normal_tx_release)
    begin
      tx_outcome_reg_ff <= tx_outcome_in; // RULE13
    end
  end

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      rdata_ff <= ria_pkg::DATA_RST;
    end
    else if (req_in.rd)
    begin
      unique case (req_in.addr)
        ria_pkg::ADDR_FLAGS: rdata_ff <= irq_event_flags_ff; // RULE2
        ria_pkg::ADDR_MASK:  rdata_ff <= irq_source_mask_ff;
        ria_pkg::ADDR_CFG:   rdata_ff <= {6'h00, cfg_ff}; // RULE11
        ria_pkg::ADDR_RSSI:  rdata_ff <= rssi_ff; // RULE12
        ria_pkg::ADDR_TXOUT: rdata_ff <= tx_outcome_reg_ff;
        default:             rdata_ff <= ria_pkg::DATA_RST;
      endcase
    end
  end

  // Pending is a level, so the pin holds until flags clear or get masked.
  assign enabled_flags = irq_event_flags_ff & ~irq_source_mask_ff; // RULE3
  assign pending       = |enabled_flags; // RULE1 RULE5

  // Reset shows the idle level of the reset polarity, so no false request is seen.
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      irq_ff <= ~ria_pkg::CFG_RST[ria_pkg::BIT_POL]; // RULE4
    end
    else
    begin
      irq_ff <= pin_level(pending, cfg_ff[ria_pkg::BIT_POL]); // RULE4
    end
  end

  assign rdata_out           = rdata_ff;
  assign irq_out             = irq_ff;
  assign sleep_clock_off_out = cfg_ff[ria_pkg::BIT_SLPOFF]; // RULE10

  // The pin is registered, so every pin check looks one cycle after its cause.
  pin_follows_a: assert property (@(posedge clk_in) disable iff (rst_in) // RULE5
    irq_out == pin_level($past(pending), $past(cfg_ff[ria_pkg::BIT_POL])))
    else $error("irq pin level wrong");
  flag_sticky_a: assert property (@(posedge clk_in) disable iff (rst_in) // RULE15
    evt_vec[ria_pkg::BIT_RXOK] |=> irq_event_flags_ff[ria_pkg::BIT_RXOK])
    else $error("rx event lost");
  read_clear_a: assert property (@(posedge clk_in) disable iff (rst_in) // RULE2
    flags_rd && evt_vec == 8'h00 |=> irq_event_flags_ff == ria_pkg::FLAGS_RST)
    else $error("read did not clear");
  read_data_a: assert property (@(posedge clk_in) disable iff (rst_in) // RULE2
    flags_rd |=> rdata_out == $past(irq_event_flags_ff))
    else $error("flag read data wrong");
  mask_blocks_a: assert property (@(posedge clk_in) disable iff (rst_in) // RULE3
    irq_source_mask_ff == ria_pkg::MASK_RST |=> irq_out == ~$past(cfg_ff[ria_pkg::BIT_POL]))
    else $error("masked irq asserted");
  cfg_upper_a: assert property (@(posedge clk_in) disable iff (rst_in) // RULE11
    $past(req_in.rd) && $past(req_in.addr) == ria_pkg::ADDR_CFG |-> rdata_out[7:2] == 6'h00)
    else $error("cfg upper nonzero");
  sleep_off_a: assert property (@(posedge clk_in) disable iff (rst_in) // RULE10
    cfg_wr |=> sleep_clock_off_out == $past(req_in.wdata[ria_pkg::BIT_SLPOFF]))
    else $error("sleep bit wrong");
  mask_write_a: assert property (@(posedge clk_in) disable iff (rst_in) // RULE9
    mask_wr |=> irq_source_mask_ff == $past(req_in.wdata))
    else $error("mask write lost");
  txout_a: assert property (@(posedge clk_in) disable iff (rst_in) // RULE13
    evt_in.normal_tx_release |=> tx_outcome_reg_ff == $past(tx_outcome_in) && irq_event_flags_ff[0])
    else $error("tx outcome not captured");

  // Each source is checked on its own, so a swapped bit cannot hide behind another.
  sleep_keep_a: assert property (@(posedge clk_in) disable iff (rst_in) // RULE15
    evt_vec[ria_pkg::BIT_SLEEP] |=> irq_event_flags_ff[ria_pkg::BIT_SLEEP])
    else $error("sleep event lost");
  wake_keep_a: assert property (@(posedge clk_in) disable iff (rst_in) // RULE15
    evt_vec[ria_pkg::BIT_WAKE] |=> irq_event_flags_ff[ria_pkg::BIT_WAKE])
    else $error("wake event lost");
  hsym_keep_a: assert property (@(posedge clk_in) disable iff (rst_in) // RULE15
    evt_vec[ria_pkg::BIT_HSYM] |=> irq_event_flags_ff[ria_pkg::BIT_HSYM])
    else $error("half symbol event lost");
  key_keep_a: assert property (@(posedge clk_in) disable iff (rst_in) // RULE15
    evt_vec[ria_pkg::BIT_KEY] |=> irq_event_flags_ff[ria_pkg::BIT_KEY])
    else $error("key event lost");
  slot2_keep_a: assert property (@(posedge clk_in) disable iff (rst_in) // RULE15
    evt_vec[ria_pkg::BIT_SLOT2] |=> irq_event_flags_ff[ria_pkg::BIT_SLOT2])
    else $error("slot2 event lost");
  slot1_keep_a: assert property (@(posedge clk_in) disable iff (rst_in) // RULE15
    evt_vec[ria_pkg::BIT_SLOT1] |=> irq_event_flags_ff[ria_pkg::BIT_SLOT1])
    else $error("slot1 event lost");
  normtx_keep_a: assert property (@(posedge clk_in) disable iff (rst_in) // RULE15
    evt_vec[ria_pkg::BIT_NORMTX] |=> irq_event_flags_ff[ria_pkg::BIT_NORMTX])
    else $error("normal tx event lost");

  sleep_drive_a: assert property (@(posedge clk_in) disable iff (rst_in) // RULE1
    enabled_flags[ria_pkg::BIT_SLEEP] |=> irq_out == $past(cfg_ff[ria_pkg::BIT_POL]))
    else $error("sleep did not drive pin");
  wake_drive_a: assert property (@(posedge clk_in) disable iff (rst_in) // RULE1
    enabled_flags[ria_pkg::BIT_WAKE] |=> irq_out == $past(cfg_ff[ria_pkg::BIT_POL]))
    else $error("wake did not drive pin");
  hsym_drive_a: assert property (@(posedge clk_in) disable iff (rst_in) // RULE1
    enabled_flags[ria_pkg::BIT_HSYM] |=> irq_out == $past(cfg_ff[ria_pkg::BIT_POL]))
    else $error("half symbol did not drive pin");
  key_drive_a: assert property (@(posedge clk_in) disable iff (rst_in) // RULE1
    enabled_flags[ria_pkg::BIT_KEY] |=> irq_out == $past(cfg_ff[ria_pkg::BIT_POL]))
    else $error("key did not drive pin");
  rx_drive_a: assert property (@(posedge clk_in) disable iff (rst_in) // RULE1
    enabled_flags[ria_pkg::BIT_RXOK] |=> irq_out == $past(cfg_ff[ria_pkg::BIT_POL]))
    else $error("rx did not drive pin");
  slot2_drive_a: assert property (@(posedge clk_in) disable iff (rst_in) // RULE1
    enabled_flags[ria_pkg::BIT_SLOT2] |=> irq_out == $past(cfg_ff[ria_pkg::BIT_POL]))
    else $error("slot2 did not drive pin");
  slot1_drive_a: assert property (@(posedge clk_in) disable iff (rst_in) // RULE1
    enabled_flags[ria_pkg::BIT_SLOT1] |=> irq_out == $past(cfg_ff[ria_pkg::BIT_POL]))
    else $error("slot1 did not drive pin");
  normtx_drive_a: assert property (@(posedge clk_in) disable iff (rst_in) // RULE1
    enabled_flags[ria_pkg::BIT_NORMTX] |=> irq_out == $past(cfg_ff[ria_pkg::BIT_POL]))
    else $error("normal tx did not drive pin");

  sleep_hold_a: assert property (@(posedge clk_in) disable iff (rst_in) // RULE5
    !evt_vec[ria_pkg::BIT_SLEEP] && !flags_rd |=> $stable(irq_event_flags_ff[ria_pkg::BIT_SLEEP]))
    else $error("sleep flag changed");
  wake_hold_a: assert property (@(posedge clk_in) disable iff (rst_in) // RULE5
    !evt_vec[ria_pkg::BIT_WAKE] && !flags_rd |=> $stable(irq_event_flags_ff[ria_pkg::BIT_WAKE]))
    else $error("wake flag changed");
  hsym_hold_a: assert property (@(posedge clk_in) disable iff (rst_in) // RULE5
    !evt_vec[ria_pkg::BIT_HSYM] && !flags_rd |=> $stable(irq_event_flags_ff[ria_pkg::BIT_HSYM]))
    else $error("half symbol flag changed");
  key_hold_a: assert property (@(posedge clk_in) disable iff (rst_in) // RULE5
    !evt_vec[ria_pkg::BIT_KEY] && !flags_rd |=> $stable(irq_event_flags_ff[ria_pkg::BIT_KEY]))
    else $error("key flag changed");
  rx_hold_a: assert property (@(posedge clk_in) disable iff (rst_in) // RULE5
    !evt_vec[ria_pkg::BIT_RXOK] && !flags_rd |=> $stable(irq_event_flags_ff[ria_pkg::BIT_RXOK]))
    else $error("rx flag changed");
  slot2_hold_a: assert property (@(posedge clk_in) disable iff (rst_in) // RULE5
    !evt_vec[ria_pkg::BIT_SLOT2] && !flags_rd |=> $stable(irq_event_flags_ff[ria_pkg::BIT_SLOT2]))
    else $error("slot2 flag changed");
  slot1_hold_a: assert property (@(posedge clk_in) disable iff (rst_in) // RULE5
    !evt_vec[ria_pkg::BIT_SLOT1] && !flags_rd |=> $stable(irq_event_flags_ff[ria_pkg::BIT_SLOT1]))
    else $error("slot1 flag changed");
  normtx_hold_a: assert property (@(posedge clk_in) disable iff (rst_in) // RULE5
    !evt_vec[ria_pkg::BIT_NORMTX] && !flags_rd |=> $stable(irq_event_flags_ff[ria_pkg::BIT_NORMTX]))
    else $error("normal tx flag changed");

  mask_hold_a: assert property (@(posedge clk_in) disable iff (rst_in) // RULE9
    !mask_wr |=> $stable(irq_source_mask_ff))
    else $error("mask changed without write");
  mask_read_a: assert property (@(posedge clk_in) disable iff (rst_in) // RULE9
    reg_read_hit(req_in, ria_pkg::ADDR_MASK) |=> rdata_out == $past(irq_source_mask_ff))
    else $error("mask read data wrong");
  cfg_hold_a: assert property (@(posedge clk_in) disable iff (rst_in) // RULE4
    !cfg_wr |=> $stable(cfg_ff))
    else $error("config changed without write");
  rssi_load_a: assert property (@(posedge clk_in) disable iff (rst_in) // RULE12
    rssi_valid_in |=> rssi_ff == $past(rssi_sample_in))
    else $error("signal sample not loaded");
  rssi_hold_a: assert property (@(posedge clk_in) disable iff (rst_in) // RULE12
    !rssi_valid_in |=> $stable(rssi_ff))
    else $error("signal sample changed");
  txout_hold_a: assert property (@(posedge clk_in) disable iff (rst_in) // RULE13
    !evt_in.normal_tx_release |=> $stable(tx_outcome_reg_ff))
    else $error("tx outcome changed");
  rdata_hold_a: assert property (@(posedge clk_in) disable iff (rst_in) // RULE2
    !req_in.rd |=> $stable(rdata_out))
    else $error("read data changed without read");
  unmapped_read_a: assert property (@(posedge clk_in) disable iff (rst_in) // RULE11
    req_in.rd && req_in.addr > ria_pkg::ADDR_TXOUT |=> rdata_out == ria_pkg::DATA_RST)
    else $error("unmapped read nonzero");

  irq_seen_c: cover property (@(posedge clk_in) disable iff (rst_in) pending ##1 irq_out == cfg_ff[1]);
  race_c: cover property (@(posedge clk_in) disable iff (rst_in) flags_rd && evt_vec != 8'h00);
  pol_high_c: cover property (@(posedge clk_in) disable iff (rst_in) cfg_ff[1] && pending);
  mask_off_c: cover property (@(posedge clk_in) disable iff (rst_in)
    pending && mask_wr && req_in.wdata == ria_pkg::MASK_RST);
  idle_low_pol_c: cover property (@(posedge clk_in) disable iff (rst_in)
    !cfg_ff[ria_pkg::BIT_POL] && !pending ##1 irq_out);
endmodule

// file: hdl/ria_pkg.sv
// Constants, register map and carrier types for the radio interrupt aggregator.
// Assumes a host-side register port that presents one access per cycle at clk_in.
// Operation
// RULE1: One interrupt output pin signals every enabled event source.
// RULE2: Event flags reset to zero; a read returns them and clears all.
// RULE3: Mask bit one blocks its event, zero enables it; mask resets all ones.
// RULE4: Configuration bit 1 selects pin active level; one high, zero low; resets zero.
// RULE5: Pin stays active until every causing flag is cleared or masked.
// RULE6: Host polls each flag to find which sources caused the interrupt.
// RULE7: Host should handle every flag returned, since the read clears all.
// RULE8: Flag positions: 7 sleep, 6 wake, 5 half-symbol, 4 key, 3 rx, 2..0 transmit.
// RULE9: Mask bits sit at the same positions as their matching flags.
// RULE10: Configuration bit 0 turns the sleep clock off when one; resets zero.
// RULE11: Configuration bits 7 to 2 read zero and ignore writes.
// RULE12: Received signal strength sample is held in a host-readable register.
// RULE13: Normal transmit completion sets its flag with outcome in the outcome register.
// RULE14: Frame passing receive filters sets the receive-ok flag, bit 3.
// RULE15: An event in the same cycle as a flag read is kept for the next read.
package ria_pkg;
  localparam logic [7:0] ADDR_FLAGS   = 8'h00;
  localparam logic [7:0] ADDR_MASK    = 8'h01;
  localparam logic [7:0] ADDR_CFG     = 8'h02;
  localparam logic [7:0] ADDR_RSSI    = 8'h03;
  localparam logic [7:0] ADDR_TXOUT   = 8'h04;
  localparam int         BIT_SLEEP    = 7;
  localparam int         BIT_WAKE     = 6;
  localparam int         BIT_HSYM     = 5;
  localparam int         BIT_KEY      = 4;
  localparam int         BIT_RXOK     = 3;
  localparam int         BIT_SLOT2    = 2;
  localparam int         BIT_SLOT1    = 1;
  localparam int         BIT_NORMTX   = 0;
  localparam int         BIT_POL      = 1;
  localparam int         BIT_SLPOFF   = 0;
  localparam logic [7:0] FLAGS_RST    = 8'h00;
  localparam logic [7:0] MASK_RST     = 8'hFF;
  localparam logic [1:0] CFG_RST      = 2'h0;
  localparam logic [7:0] DATA_RST     = 8'h00;

  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } ria_req_t;

  typedef struct packed {
    logic       sleep_alert;
    logic       wake_alert;
    logic       half_symbol_timer;
    logic       key_request;
    logic       rx_ok;
    logic       slot2_release;
    logic       slot1_release;
    logic       normal_tx_release;
  } ria_evt_t;
endpackage

// file: dv/ria_host_model.sv
// Host side view of the single interrupt pin.
// Assumes the bench mirrors the polarity bit it writes.
`timescale 1ns/1ns
module ria_host_model (
  input  wire logic irq_in,
  input  wire logic pol_in,
  output logic      active_out
);
  // Level decode, so a host that misses an edge still sees the pending state.
  assign active_out = (irq_in === pol_in);
endmodule

// file: dv/tb.sv
// Self-checking bench for the interrupt aggregator.
// Assumes the host model decodes the pin level.
`timescale 1ns/1ns
module tb;
  logic              clk_in = 1'b0, rst_in = 1'b1, rv = 1'b0, pol = 1'b0, irq, slp, act;
  logic [7:0]        rs = 8'h00, txo = 8'h3C, rd;
  ria_pkg::ria_req_t req = '0;
  ria_pkg::ria_evt_t evt = '0;
  int                err_total = 0, num_checks = 0, cyc = 0;
  always #20 clk_in = ~clk_in;
  ria_top u_ria_top (.clk_in(clk_in), .rst_in(rst_in), .req_in(req), .evt_in(evt), .rssi_sample_in(rs),
    .rssi_valid_in(rv), .tx_outcome_in(txo), .rdata_out(rd), .irq_out(irq), .sleep_clock_off_out(slp));
  ria_host_model u_ria_host_model (.irq_in(irq), .pol_in(pol), .active_out(act));
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    num_checks++;
    if (g !== e)
    begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_in) req = {~w, w, a, d};
    @(negedge clk_in) req = '0;
  endtask
  task automatic pulse(input logic [7:0] v);
    @(negedge clk_in) evt = v;
    @(negedge clk_in) evt = '0;
  endtask
  // The pin lags the flags by one cycle, hence the extra edge.
  task automatic act_is(input logic e);
    @(negedge clk_in);
    chk({7'h00, act}, {7'h00, e});
  endtask
  task automatic t_reset;
    acc(0, ria_pkg::ADDR_MASK, 8'h00); chk(rd, 8'hFF);
    acc(0, ria_pkg::ADDR_CFG, 8'h00); chk(rd, 8'h00);
    chk({7'h00, slp}, 8'h00);
    chk({7'h00, irq}, 8'h01);
    acc(0, ria_pkg::ADDR_FLAGS, 8'h00); chk(rd, 8'h00);
    act_is(0);
  endtask
  task automatic t_bits;
    for (int i = 0; i < 8; i++)
    begin
      pulse(8'h01 << i); act_is(0);
      acc(0, ria_pkg::ADDR_FLAGS, 8'h00); chk(rd, 8'h01 << i);
      acc(0, ria_pkg::ADDR_FLAGS, 8'h00); chk(rd, 8'h00);
    end
    @(negedge clk_in) txo = 8'hA5;
    acc(0, ria_pkg::ADDR_TXOUT, 8'h00); chk(rd, 8'h3C);
    pulse(8'h01); acc(0, ria_pkg::ADDR_TXOUT, 8'h00); chk(rd, 8'hA5);
    acc(0, ria_pkg::ADDR_FLAGS, 8'h00); chk(rd, 8'h01);
  endtask
  task automatic t_irq;
    acc(1, ria_pkg::ADDR_MASK, 8'hF7); pulse(8'h08); act_is(1);
    pulse(8'h10); act_is(1);
    acc(0, ria_pkg::ADDR_FLAGS, 8'h00); chk(rd, 8'h18);
    act_is(0);
    pulse(8'h08); act_is(1); acc(1, ria_pkg::ADDR_MASK, 8'hFF); act_is(0);
    acc(0, ria_pkg::ADDR_FLAGS, 8'h00); chk(rd, 8'h08);
  endtask
  task automatic t_cfg;
    acc(1, ria_pkg::ADDR_CFG, 8'hFF); pol = 1'b1; act_is(0);
    acc(0, ria_pkg::ADDR_CFG, 8'h00); chk(rd, 8'h03);
    chk({7'h00, slp}, 8'h01);
    acc(1, ria_pkg::ADDR_CFG, 8'h02); chk({7'h00, slp}, 8'h00);
    acc(1, ria_pkg::ADDR_MASK, 8'hF7); pulse(8'h08); act_is(1);
    acc(0, ria_pkg::ADDR_FLAGS, 8'h00); chk(rd, 8'h08);
  endtask
  task automatic t_race;
    @(negedge clk_in) req = {2'b10, ria_pkg::ADDR_FLAGS, 8'h00};
    evt = 8'h40;
    @(negedge clk_in) req = '0;
    evt = '0;
    chk(rd, 8'h00);
    acc(0, ria_pkg::ADDR_FLAGS, 8'h00); chk(rd, 8'h40);
  endtask
  task automatic t_rssi;
    @(negedge clk_in) rs = 8'h5A;
    rv = 1'b1;
    @(negedge clk_in) rv = 1'b0;
    acc(1, ria_pkg::ADDR_RSSI, 8'h00); acc(0, ria_pkg::ADDR_RSSI, 8'h00); chk(rd, 8'h5A);
    @(negedge clk_in) rs = 8'hC3;
    acc(0, ria_pkg::ADDR_RSSI, 8'h00); chk(rd, 8'h5A);
    acc(1, ria_pkg::ADDR_FLAGS, 8'hFF); acc(0, ria_pkg::ADDR_FLAGS, 8'h00); chk(rd, 8'h00);
    acc(0, 8'h07, 8'h00); chk(rd, 8'h00);
  endtask
  // A second reset mid-run must drop pending flags and park the pin at its idle level.
  task automatic t_rearm;
    pulse(8'h08); act_is(1);
    @(negedge clk_in) rst_in = 1'b1;
    @(negedge clk_in) chk({7'h00, irq}, 8'h01);
    rst_in = 1'b0;
    pol = 1'b0;
    t_reset();
  endtask
  task automatic tally_and_finish;
    $display("checks=%0d errors=%0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  always @(posedge clk_in)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      err_total++;
      tally_and_finish();
    end
  end
  initial
  begin
    repeat (12) @(negedge clk_in);
    rst_in = 1'b0;
    t_reset(); t_bits(); t_irq(); t_cfg(); t_race(); t_rssi(); t_rearm();
    tally_and_finish();
  end
endmodule
